// *** rtl/eep_slave_top.sv ***
// two-wire serial eeprom slave: protocol engine, page buffer, array
// assumes nrst is the power-on reset and the bus pins have external pull-ups
`timescale 1ns/10ps
module eep_slave_top
#(
  parameter int PU_CYCLES = eep_pkg::PU_CYC,
  parameter int WR_CYCLES = eep_pkg::WR_CYC
)
(
  // core clock and power-on reset
  input wire logic core_clk,
  input wire logic nrst,
  // link sample clock
  input wire logic link_clk,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // strap pins
  input wire logic chip_select_addr_bit0,
  input wire logic chip_select_addr_bit1,
  input wire logic chip_select_addr_bit2,
  input wire logic wp_i,
  // status
  output logic ready,
  output logic write_busy
);
  // ************************************************************
  // core domain: power-up delay and write cycle timer
  // ************************************************************
  logic [eep_pkg::CNT_W-1:0] pu_cnt_q;
  logic ready_q;
  logic [eep_pkg::CNT_W-1:0] wr_cnt_q;
  logic busy_q;
  logic wt_s1_q, wt_s2_q, wt_s3_q;
  logic wr_tgl_q;

  // reset state until supply is good, then standby after the delay [R2] [R3] [R4]
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      pu_cnt_q <= '0;
      ready_q <= 1'b0;
    end
    else if (pu_cnt_q == eep_pkg::CNT_W'(PU_CYCLES - 1))
    begin
      ready_q <= 1'b1;
    end
    else
    begin
      pu_cnt_q <= pu_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    wt_s1_q <= wr_tgl_q;
    wt_s2_q <= wt_s1_q;
    wt_s3_q <= wt_s2_q;
  end

  // self-timed internal write [R12]
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wr_cnt_q <= '0;
      busy_q <= 1'b0;
    end
    else if (wt_s2_q ^ wt_s3_q)
    begin
      wr_cnt_q <= '0;
      busy_q <= 1'b1;
    end
    else if (busy_q)
    begin
      if (wr_cnt_q == eep_pkg::CNT_W'(WR_CYCLES - 1))
        busy_q <= 1'b0;
      else
        wr_cnt_q <= wr_cnt_q + 1'b1;
    end
  end

  assign ready = ready_q;
  assign write_busy = busy_q;

  // ************************************************************
  // link domain: reset, crossings, pin sampling
  // ************************************************************
  logic lr1_q, lrst_n;
  logic rdy_s1_q, rdy_s2_q, bsy_s1_q, bsy_s2_q;
  logic [3:0] pin_s1_q, pin_s2_q;
  eep_pkg::eep_bus_s raw_bus, filt_bus;
  logic scl_d_q, sda_d_q;
  logic rise, fall, start_c, stop_c;

  always_ff @(posedge link_clk)
  begin
    lr1_q <= nrst;
    lrst_n <= lr1_q;
    rdy_s1_q <= ready_q;
    rdy_s2_q <= rdy_s1_q;
    bsy_s1_q <= busy_q;
    bsy_s2_q <= bsy_s1_q;
  end

  // straps: an undriven pin is pulled low outside, reset value low [R1]
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= {wp_i, chip_select_addr_bit2, chip_select_addr_bit1, chip_select_addr_bit0};
      pin_s2_q <= pin_s1_q;
    end
  end

  // one driver for the whole carrier
  assign raw_bus = '{scl: scl_i, sda: sda_i};

  eep_glitch_filt u_filt
  (
    .link_clk(link_clk),
    .lrst_n(lrst_n),
    .raw(raw_bus),
    .filt(filt_bus)
  );

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= filt_bus.scl;
      sda_d_q <= filt_bus.sda;
    end
  end

  // the master alone makes clock edges and bus conditions [R9]
  assign rise = filt_bus.scl & ~scl_d_q;
  assign fall = ~filt_bus.scl & scl_d_q;
  assign start_c = filt_bus.scl & scl_d_q & sda_d_q & ~filt_bus.sda;
  assign stop_c = filt_bus.scl & scl_d_q & ~sda_d_q & filt_bus.sda;

  // ************************************************************
  // protocol engine
  // ************************************************************
  eep_pkg::eep_state_e st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q, tx_q, addr_q;
  logic oe_q, mack_q, wpblk_q, commit_q, pend_q;
  logic [7:0] pbuf_q [eep_pkg::PAGE_LEN];
  logic [eep_pkg::PAGE_LEN-1:0] pval_q;
  logic [7:0] mem_q [eep_pkg::MEM_DEPTH];
  logic match;

  // type, then strap pins, device not busy [R7] [R13] [R16]
  assign match = (sh_q[7:4] == eep_pkg::DEV_TYPE) && (sh_q[3:1] == pin_s2_q[2:0]) && rdy_s2_q && !pend_q
    && !bsy_s2_q;

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      st_q <= eep_pkg::ST_IDLE;
      bit_q <= '0;
      sh_q <= '0;
      tx_q <= '0;
      addr_q <= '0;
      oe_q <= 1'b0;
      mack_q <= 1'b0;
      wpblk_q <= 1'b0;
      commit_q <= 1'b0;
      pval_q <= '0;
    end
    else
    begin
      commit_q <= 1'b0;
      if (commit_q)
        pval_q <= '0;
      if (start_c)
      begin
        st_q <= eep_pkg::ST_DEV;
        bit_q <= '0;
        oe_q <= 1'b0;
        pval_q <= '0;
      end
      else if (stop_c)
      begin
        commit_q <= (st_q == eep_pkg::ST_WDAT) && (pval_q != '0);
        st_q <= eep_pkg::ST_IDLE;
        oe_q <= 1'b0;
      end
      else if (rise && st_q != eep_pkg::ST_IDLE)
      begin
        // data taken on the rising edge [R5]
        if (bit_q < eep_pkg::BIT_ACK)
        begin
          sh_q <= {sh_q[6:0], filt_bus.sda};
          bit_q <= bit_q + 1'b1;
        end
        else if (bit_q == eep_pkg::BIT_ACK && st_q == eep_pkg::ST_RDAT)
        begin
          mack_q <= ~filt_bus.sda;
          bit_q <= eep_pkg::BIT_END;
        end
      end
      else if (fall)
      begin
        // output changes only after the falling edge [R5] [R10]
        unique case (st_q)
          eep_pkg::ST_IDLE:
          begin
            oe_q <= 1'b0;
          end
          eep_pkg::ST_DEV:
          begin
            if (bit_q == eep_pkg::BIT_ACK)
            begin
              if (match)
              begin
                oe_q <= 1'b1; // [R14]
                bit_q <= eep_pkg::BIT_END;
              end
              else
                st_q <= eep_pkg::ST_IDLE; // [R16]
            end
            else if (bit_q == eep_pkg::BIT_END)
            begin
              bit_q <= '0;
              if (sh_q[0])
              begin
                st_q <= eep_pkg::ST_RDAT;
                tx_q <= mem_q[addr_q];
                oe_q <= ~mem_q[addr_q][7];
              end
              else
              begin
                st_q <= eep_pkg::ST_WADR;
                oe_q <= 1'b0;
              end
            end
          end
          eep_pkg::ST_WADR:
          begin
            if (bit_q == eep_pkg::BIT_ACK)
            begin
              addr_q <= sh_q;
              oe_q <= 1'b1; // [R14]
              bit_q <= eep_pkg::BIT_END;
            end
            else if (bit_q == eep_pkg::BIT_END)
            begin
              wpblk_q <= pin_s2_q[3]; // [R15]
              oe_q <= 1'b0;
              bit_q <= '0;
              st_q <= eep_pkg::ST_WDAT;
            end
          end
          eep_pkg::ST_WDAT:
          begin
            if (bit_q == eep_pkg::BIT_ACK)
            begin
              if (wpblk_q)
              begin
                oe_q <= 1'b0; // [R8] [R15]
                st_q <= eep_pkg::ST_IDLE;
              end
              else
              begin
                pbuf_q[addr_q[3:0]] <= sh_q;
                pval_q[addr_q[3:0]] <= 1'b1;
                addr_q[3:0] <= addr_q[3:0] + 1'b1;
                oe_q <= 1'b1; // [R14]
                bit_q <= eep_pkg::BIT_END;
              end
            end
            else if (bit_q == eep_pkg::BIT_END)
            begin
              oe_q <= 1'b0;
              bit_q <= '0;
            end
          end
          eep_pkg::ST_RDAT:
          begin
            if (bit_q == eep_pkg::BIT_ACK)
            begin
              oe_q <= 1'b0;
              addr_q <= addr_q + 1'b1;
            end
            else if (bit_q == eep_pkg::BIT_END)
            begin
              bit_q <= '0;
              if (mack_q)
              begin
                tx_q <= mem_q[addr_q];
                oe_q <= ~mem_q[addr_q][7];
              end
              else
                st_q <= eep_pkg::ST_IDLE;
            end
            else if (bit_q != '0)
            begin
              oe_q <= ~tx_q[6]; // [R6]
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          default:
          begin
            st_q <= eep_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // array commit and write handoff
  // ************************************************************
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      for (int i = 0; i < eep_pkg::MEM_DEPTH; i++)
        mem_q[i] <= eep_pkg::ERASED;
    end
    else if (commit_q)
    begin
      for (int i = 0; i < eep_pkg::PAGE_LEN; i++)
        if (pval_q[i])
          mem_q[{addr_q[7:4], 4'(i)}] <= pbuf_q[i];
    end
  end

  // local busy until the core timer has visibly taken over [R12] [R16]
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      pend_q <= 1'b0;
      wr_tgl_q <= 1'b0;
    end
    else if (commit_q)
    begin
      pend_q <= 1'b1;
      wr_tgl_q <= ~wr_tgl_q;
    end
    else if (bsy_s2_q)
      pend_q <= 1'b0;
  end

  // only ever pulls low [R6]
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      sda_oe <= oe_q;
    end
  end
endmodule

// *** rtl/eep_pkg.sv ***
// constants, types and timing counts for the serial eeprom slave
// assumes a 20 mhz core clock and a free running link sample clock
// Function
// R1 - undriven address and protect pins read low
// R2 - after power-on reset, come up in standby
// R3 - supply below threshold forces reset state
// R4 - accept commands within 1 ms of power
// R5 - sample on scl rise, change on fall
// R6 - sda open drain, only pull low
// R7 - address pins form the bus address
// R8 - protect pin high refuses all writes
// R9 - master makes scl, start and stop
// R10 - slave only, receive or transmit per command
// R11 - ignore glitches under 100 ns
// R12 - internal write finishes within 5 ms
// R13 - answer only 1010, pins, then rw bit
// R14 - ack on ninth clock after each byte
// R15 - protect sampled before first data byte, abort
// R16 - no ack while internal write runs
package eep_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_HZ = 20_000_000;
  localparam int T_PU_US = 1000;
  localparam int T_WR_US = 5000;
  localparam int PU_CYC = T_PU_US * (CORE_HZ / 1_000_000);
  localparam int WR_CYC = T_WR_US * (CORE_HZ / 1_000_000);
  localparam int T_GLITCH_NS = 100;
  localparam int LINK_PERIOD_NS = 6;
  localparam int GLITCH_CYC = (T_GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int CNT_W = 17;
  localparam int GF_W = 5;

  // ************************************************************
  // addressing and memory
  // ************************************************************
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_LEN = 16;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed
  {
    logic scl;
    logic sda;
  } eep_bus_s;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_DEV = 3'h1,
    ST_WADR = 3'h3,
    ST_WDAT = 3'h2,
    ST_RDAT = 3'h6
  } eep_state_e;
endpackage

// *** rtl/eep_glitch_filt.sv ***
// two-flop synchroniser and stability filter for the scl and sda pins
// assumes the link sample clock is much faster than the bus clock
`timescale 1ns/10ps
module eep_glitch_filt
(
  // clock and reset
  input wire logic link_clk,
  input wire logic lrst_n,
  // pins
  input wire eep_pkg::eep_bus_s raw,
  output eep_pkg::eep_bus_s filt
);
  logic [1:0] raw_v;
  logic [1:0] filt_v;

  assign raw_v = raw;
  assign filt = filt_v;

  // ************************************************************
  // one filter per line
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_line
      logic s1_q;
      logic s2_q;
      logic out_q;
      logic [eep_pkg::GF_W-1:0] cnt_q;

      always_ff @(posedge link_clk)
      begin
        s1_q <= raw_v[g];
        s2_q <= s1_q;
      end

      // output follows only after the line is stable long enough [R11]
      always_ff @(posedge link_clk)
      begin
        if (!lrst_n)
        begin
          out_q <= 1'b1;
          cnt_q <= '0;
        end
        else if (s2_q == out_q)
        begin
          cnt_q <= '0;
        end
        else if (cnt_q == eep_pkg::GF_W'(eep_pkg::GLITCH_CYC - 1))
        begin
          out_q <= s2_q;
          cnt_q <= '0;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end

      assign filt_v[g] = out_q;
    end
  endgenerate
endmodule

// *** verification/eep_properties.sv ***
// concurrent checks on the eeprom slave top ports
// bound to eep_slave_top below; core and link clock domains
`timescale 1ns/10ps
module eep_props
#(
  parameter int PU_CYCLES = 50,
  parameter int WR_CYCLES = 200
)
(
  // clocks and reset
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic nrst,
  // pins and status
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic ready,
  input wire logic write_busy
);
  // ******
  // checks
  // ******
  int pu_cnt_q;
  int busy_cnt_q;
  always_ff @(posedge core_clk)
    pu_cnt_q <= !nrst ? 0 : (ready ? pu_cnt_q : pu_cnt_q + 1);
  always_ff @(posedge core_clk)
    busy_cnt_q <= (!nrst || !write_busy) ? 0 : busy_cnt_q + 1;
  sequence s_ack_begin;
    $rose(sda_oe);
  endsequence
  sequence s_ack_hold;
    sda_oe [*8];
  endsequence
  AST_SDA_O_LOW:
    assert property (@(posedge link_clk) disable iff (!nrst) !sda_o) else $error("sda driven high");
  AST_RST_QUIET:
    assert property (@(posedge core_clk) disable iff (!nrst) $rose(nrst) |-> !ready && !write_busy)
    else $error("status up at reset release");
  AST_READY_STAYS:
    assert property (@(posedge core_clk) disable iff (!nrst) ready |=> ready) else $error("ready dropped");
  AST_READY_BY:
    assert property (@(posedge core_clk) disable iff (!nrst) pu_cnt_q <= PU_CYCLES + 1) else $error("ready late");
  AST_BUSY_NEEDS_READY:
    assert property (@(posedge core_clk) disable iff (!nrst) write_busy |-> ready) else $error("busy before ready");
  AST_OE_BEFORE_READY:
    assert property (@(posedge link_clk) disable iff (!nrst) !ready |-> !sda_oe) else $error("answer before ready");
  AST_OE_SCL_LOW:
    assert property (@(posedge link_clk) disable iff (!nrst) $changed(sda_oe) |-> !scl_i)
    else $error("sda changed with scl high");
  AST_NO_ACK_BUSY:
    assert property (@(posedge link_clk) disable iff (!nrst) s_ack_begin |-> !write_busy) else $error("ack while busy");
  AST_ACK_HOLD:
    assert property (@(posedge link_clk) disable iff (!nrst) s_ack_begin |-> s_ack_hold) else $error("pull too short");
  AST_BUSY_BOUND:
    assert property (@(posedge core_clk) disable iff (!nrst) busy_cnt_q <= WR_CYCLES + 1) else $error("write too long");
endmodule

bind eep_slave_top eep_props #(.PU_CYCLES(PU_CYCLES), .WR_CYCLES(WR_CYCLES)) u_eep_props
(
  .core_clk(core_clk),
  .link_clk(link_clk),
  .nrst(nrst),
  .scl_i(scl_i),
  .sda_o(sda_o),
  .sda_oe(sda_oe),
  .ready(ready),
  .write_busy(write_busy)
);

// *** verification/eep_mst_model.sv ***
// two-wire bus master model: drives scl, pulls sda low or releases it
// assumes the bench resolves sda with a pull-up
`timescale 1ns/10ps
module eep_mst_model
#(
  parameter int QTR_NS = 500
)
(
  // control
  input wire logic glitch_en,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // ******
  // bus cycles
  // ******
  logic [8:0] res;
  event res_ev;
  initial
  begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic start();
    sda_pull = 1'h0;
    #QTR_NS scl = 1'h1;
    #QTR_NS sda_pull = 1'h1;
    #QTR_NS scl = 1'h0;
    #QTR_NS;
  endtask
  task automatic stop();
    sda_pull = 1'h1;
    #QTR_NS scl = 1'h1;
    #QTR_NS sda_pull = 1'h0;
    #(2 * QTR_NS);
  endtask
  // optional short scl spike in the low phase
  task automatic bitx(input logic b, output logic r);
    #QTR_NS sda_pull = !b;
    #(QTR_NS / 2) scl = glitch_en;
    #60 scl = 1'h0;
    #(QTR_NS / 2 - 60) scl = 1'h1;
    #QTR_NS r = sda;
    #QTR_NS scl = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], res[i + 1]);
    bitx(last, res[0]);
    -> res_ev;
  endtask
endmodule

// *** verification/i2c_eeprom_slave_ctrl_tb_top.sv ***
// self-checking bench for the eeprom slave with a memory model
// assumes eep_props is bound by its own file
`timescale 1ns/10ps
module i2c_eeprom_slave_ctrl_tb_top;
  // ******
  // bench
  // ******
  localparam int PU_N = 50;
  localparam int WR_N = 1000;
  logic core_clk = 1'h0;
  logic link_clk = 1'h0;
  logic nrst = 1'h0;
  logic wp_i = 1'h0;
  logic glitch_en = 1'h0;
  logic [2:0] strap = 3'h0;
  logic [3:0] pg;
  logic [7:0] mem [256];
  logic [8:0] expq [$];
  int num_errors = 0;
  int samples_checked = 0;
  wire scl;
  wire sda_pull;
  wire sda_o;
  wire sda_oe;
  wire ready;
  wire write_busy;
  wire sda = !((sda_oe && !sda_o) || sda_pull);
  always #25 core_clk = !core_clk;
  initial
  begin
    #1.7;
    forever #3 link_clk = !link_clk;
  end
  eep_slave_top #(.PU_CYCLES(PU_N), .WR_CYCLES(WR_N)) u_eep_slave_top
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .link_clk(link_clk),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .chip_select_addr_bit0(strap[0]),
    .chip_select_addr_bit1(strap[1]),
    .chip_select_addr_bit2(strap[2]),
    .wp_i(wp_i),
    .ready(ready),
    .write_busy(write_busy)
  );
  eep_mst_model u_eep_mst_model
  (
    .glitch_en(glitch_en),
    .sda(sda),
    .scl(scl),
    .sda_pull(sda_pull)
  );
  task automatic cmp_bus(input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_lvl(input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  always @(u_eep_mst_model.res_ev)
    cmp_bus(expq.pop_front(), u_eep_mst_model.res);
  task automatic xb(input logic [7:0] d, input logic last, input logic [8:0] e);
    expq.push_back(e);
    u_eep_mst_model.xfer(d, last);
  endtask
  task automatic probe(input logic [3:0] ty, input logic [2:0] sel, input logic ack);
    u_eep_mst_model.start();
    xb({ty, sel, 1'h0}, 1'h1, {ty, sel, 1'h0, !ack});
    u_eep_mst_model.stop();
  endtask
  task automatic wr(input logic [7:0] a, input int n, input logic ok);
    logic [7:0] d;
    u_eep_mst_model.start();
    xb({4'ha, strap, 1'h0}, 1'h1, {4'ha, strap, 2'h0});
    xb(a, 1'h1, {a, 1'h0});
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      xb(d, 1'h1, {d, !ok});
      if (ok)
        mem[{a[7:4], a[3:0] + i[3:0]}] = d;
    end
    u_eep_mst_model.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    u_eep_mst_model.start();
    xb({4'ha, strap, 1'h0}, 1'h1, {4'ha, strap, 2'h0});
    xb(a, 1'h1, {a, 1'h0});
    u_eep_mst_model.start();
    xb({4'ha, strap, 1'h1}, 1'h1, {4'ha, strap, 2'h2});
    for (int i = 0; i < n; i++)
      xb(8'hff, i == n - 1, {mem[8'(a + i)], i == n - 1});
    u_eep_mst_model.stop();
  endtask
  task automatic settle(input int lim, input logic busy);
    for (int n = 0; n < lim && (busy ? write_busy !== 1'h0 : ready !== 1'h1); n++)
      @(negedge core_clk);
    cmp_lvl(!busy, busy ? write_busy : ready);
    repeat (4) @(negedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(13));
    strap = 3'($urandom);
    pg = 4'($urandom);
    foreach (mem[i]) mem[i] = 8'hff;
    repeat (10) @(negedge core_clk);
    nrst = 1'h1;
    cmp_lvl(1'h0, ready);
    settle(PU_N + 10, 1'h0);
    for (int i = 0; i < 8; i++)
      probe(4'ha, 3'(i), 3'(i) == strap);
    probe(4'hb, strap, 1'h0);
    wr({pg, 4'hf}, 3, 1'h1);
    probe(4'ha, strap, 1'h0);
    cmp_lvl(1'h1, write_busy);
    settle(WR_N + 10, 1'h1);
    wp_i = 1'h1;
    wr({pg, 4'h0}, 1, 1'h0);
    cmp_lvl(1'h0, write_busy);
    wp_i = 1'h0;
    glitch_en = 1'h1;
    wr({pg, 4'h8}, 2, 1'h1);
    glitch_en = 1'h0;
    settle(WR_N + 10, 1'h1);
    rd({pg, 4'h0}, 16);
    nrst = 1'h0;
    repeat (10) @(negedge core_clk);
    nrst = 1'h1;
    foreach (mem[i]) mem[i] = 8'hff;
    settle(PU_N + 10, 1'h0);
    rd({pg, 4'hf}, 2);
    tally_and_finish();
  end
  initial
  begin
    #3_000_000;
    num_errors++;
    tally_and_finish();
  end
endmodule
